// ---- hdl/lwm_pkg.sv ----
package lwm_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ      = 200;
  localparam int T_REARM_US   = 6;
  localparam int T_TXD_HI_US  = 10;
  localparam int T_BUS_US     = 50;
  localparam int T_WAKE_US    = 50;
  localparam int T_MON_US     = 100;
  localparam int T_PWH_US     = 3;
  localparam int N_REARM      = T_REARM_US * CLK_MHZ;
  localparam int N_TXD_HI     = T_TXD_HI_US * CLK_MHZ;
  localparam int N_BUS        = T_BUS_US * CLK_MHZ;
  localparam int N_WAKE       = T_WAKE_US * CLK_MHZ;
  localparam int N_MON        = T_MON_US * CLK_MHZ;
  localparam int N_PWH        = T_PWH_US * CLK_MHZ;
  localparam int CNT_W        = 16;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STATUS = 4'h4;
  localparam int          CTRL_REM   = 0;
  localparam int          CTRL_LOC   = 1;
  localparam logic [1:0]  CTRL_RST   = 2'h3;
  localparam int          STAT_ST    = 0;
  localparam int          STAT_FLG   = 5;
  // ---------------------------------------------------------------
  // operating states
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_SLEEP = 5'h01,
    ST_MON   = 5'h02,
    ST_SHORT = 5'h04,
    ST_FS    = 5'h08,
    ST_NORM  = 5'h10
  } lwm_state_t;
endpackage

// ---- hdl/lwm_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module lwm_ctrl #(
  parameter int CW     = lwm_pkg::CNT_W,
  parameter int NREARM = lwm_pkg::N_REARM,
  parameter int NTXD   = lwm_pkg::N_TXD_HI,
  parameter int NBUS   = lwm_pkg::N_BUS,
  parameter int NWAKE  = lwm_pkg::N_WAKE,
  parameter int NMON   = lwm_pkg::N_MON,
  parameter int NPWH   = lwm_pkg::N_PWH
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_I,
  input  wire logic        EN_I,
  input  wire logic        TX_PIN_I,
  output logic             TX_PIN_O,
  output logic             TX_PIN_OE_N_O,
  output logic             TX_WEAK_PD_O,
  output logic             RX_PIN_O,
  output logic             RX_PIN_OE_N_O,
  input  wire logic        BUS_PWL_I,
  input  wire logic        BUS_PWH_I,
  input  wire logic        BUS_DOM_I,
  input  wire logic        OT_HOT_I,
  input  wire logic        OT_COOL_I,
  input  wire logic        WAKE_I,
  output logic             REG_INHIBIT_OUT_O,
  output logic             TERM_EN_O,
  output logic             RX_EN_O,
  output logic             BUS_DRV_O,
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O
);
  import lwm_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [5:0] raw_in;
  logic [5:0] sy1_r;
  logic [5:0] sy2_r;
  logic       pwl_s, pwh_s, dom_s, hot_s, cool_s, wake_s;

  assign raw_in = {BUS_PWL_I, BUS_PWH_I, BUS_DOM_I,
                   OT_HOT_I, OT_COOL_I, WAKE_I};
  // two-stage sync per comparator
  for (genvar g = 0; g < 6; g++) begin : g_sync
    always_ff @(posedge CORE_CLK_I) begin
      sy1_r[g] <= raw_in[g];
      sy2_r[g] <= sy1_r[g];
    end
  end
  assign {pwl_s, pwh_s, dom_s, hot_s, cool_s, wake_s} = sy2_r;

  function automatic logic [CW-1:0] inc_sat(input logic [CW-1:0] v);
    inc_sat = (&v) ? v : v + 1'b1;
  endfunction

  // ---------------------------------------------------------------
  // mode and wake control
  // ---------------------------------------------------------------
  lwm_state_t    st_r, st_nxt;
  logic [CW-1:0] tmr_r, tmr_nxt, dom_r, dom_nxt, pwh_r, pwh_nxt;
  logic [CW-1:0] wlo_r, wlo_nxt, whi_r, whi_nxt, txh_r, txh_nxt;
  logic          dom_prev_r, en_prev_r, bus_arm_r, bus_arm_nxt;
  logic          wk_arm_r, wk_arm_nxt, pend_r, pend_nxt;
  logic          src_loc_r, src_loc_nxt, ot_off_r, ot_off_nxt;
  logic          txd_ok_r, txd_ok_nxt, asleep, asleep_nxt;
  logic          loc_hit, rem_hit;
  logic          inh_nxt, rxen_nxt, drv_nxt, rxoe_nxt, txoe_nxt, weak_nxt;
  logic [1:0]    ctrl_r, ctrl_nxt;

  assign asleep  = (st_r == ST_SLEEP) || (st_r == ST_MON) ||
                   (st_r == ST_SHORT);
  assign loc_hit = asleep && ctrl_r[CTRL_LOC] &&
                   (wlo_r > CW'(NWAKE));
  assign rem_hit = ((st_r == ST_MON) && dom_prev_r && !dom_s &&
                    (dom_r > CW'(NBUS))) ||
                   ((st_r == ST_SHORT) && !dom_s);

  // next state, counters and flags
  always_comb begin
    st_nxt      = st_r;
    tmr_nxt     = tmr_r;
    bus_arm_nxt = bus_arm_r;
    wk_arm_nxt  = wk_arm_r;
    pend_nxt    = pend_r;
    src_loc_nxt = src_loc_r;
    txd_ok_nxt  = txd_ok_r;
    txh_nxt     = '0;
    dom_nxt     = dom_s ? inc_sat(dom_r) : '0;
    pwh_nxt     = pwh_s ? inc_sat(pwh_r) : '0;
    whi_nxt     = wake_s ? inc_sat(whi_r) : '0;
    wlo_nxt     = (!wake_s && wk_arm_r) ? inc_sat(wlo_r) : '0;
    if (pwh_r > CW'(NPWH))
      bus_arm_nxt = 1'b1;
    if (whi_r > CW'(NREARM))
      wk_arm_nxt = 1'b1;
    // set wins over clear for the driver shutdown
    if (hot_s)
      ot_off_nxt = 1'b1;
    else if (cool_s)
      ot_off_nxt = 1'b0;
    else
      ot_off_nxt = ot_off_r;
    unique case (st_r)
      ST_SLEEP: begin
        if (ctrl_r[CTRL_REM] && bus_arm_r && pwl_s) begin
          st_nxt  = ST_MON;
          tmr_nxt = '0;
        end
      end
      ST_MON: begin
        tmr_nxt = inc_sat(tmr_r);
        if (tmr_r >= CW'(NMON)) begin
          if (dom_s) begin
            st_nxt = ST_SHORT;
          end else begin
            st_nxt      = ST_SLEEP;
            bus_arm_nxt = 1'b0;
          end
        end else if (!pwl_s && !dom_s) begin
          st_nxt = ST_SLEEP;
        end
      end
      ST_SHORT: begin
        st_nxt = ST_SHORT;
      end
      ST_FS: begin
        if (EN_I) begin
          st_nxt      = ST_NORM;
          pend_nxt    = 1'b0;
          src_loc_nxt = 1'b0;
          txd_ok_nxt  = 1'b0;
        end
      end
      ST_NORM: begin
        txh_nxt = TX_PIN_I ? inc_sat(txh_r) : '0;
        if (txh_r > CW'(NTXD))
          txd_ok_nxt = 1'b1;
        if (en_prev_r && !EN_I && TX_PIN_I) begin
          st_nxt     = ST_SLEEP;
          txd_ok_nxt = 1'b0;
          // a wake held low into sleep needs a fresh high first
          if (!wake_s)
            wk_arm_nxt = 1'b0;
        end
      end
      default: st_nxt = ST_FS;
    endcase
    // wake requests override the asleep sub-states
    if (rem_hit || loc_hit) begin
      st_nxt      = ST_FS;
      pend_nxt    = 1'b1;
      src_loc_nxt = loc_hit;
      if (loc_hit)
        wk_arm_nxt = 1'b0;
    end
    asleep_nxt = (st_nxt == ST_SLEEP) || (st_nxt == ST_MON) ||
                 (st_nxt == ST_SHORT);
    inh_nxt  = !asleep_nxt;
    rxen_nxt = (st_nxt != ST_SLEEP) && (st_nxt != ST_SHORT);
    drv_nxt  = (st_nxt == ST_NORM) && txd_ok_nxt && !ot_off_nxt &&
               !TX_PIN_I;
    // open-drain pulls: enable low while pulling low
    rxoe_nxt = !(((st_nxt == ST_FS) && pend_nxt) ||
                 ((st_nxt == ST_NORM) && dom_s));
    txoe_nxt = !((st_nxt == ST_FS) && pend_nxt && src_loc_nxt);
    weak_nxt = (st_nxt == ST_FS) && pend_nxt && !src_loc_nxt;
  end

  // registers of the control group
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      st_r              <= ST_FS;
      tmr_r             <= '0;
      dom_r             <= '0;
      pwh_r             <= '0;
      wlo_r             <= '0;
      whi_r             <= '0;
      txh_r             <= '0;
      dom_prev_r        <= 1'b0;
      en_prev_r         <= 1'b0;
      bus_arm_r         <= 1'b1;
      wk_arm_r          <= 1'b0;
      pend_r            <= 1'b0;
      src_loc_r         <= 1'b0;
      ot_off_r          <= 1'b0;
      txd_ok_r          <= 1'b0;
      REG_INHIBIT_OUT_O <= 1'b1;
      TERM_EN_O         <= 1'b1;
      RX_EN_O           <= 1'b1;
      BUS_DRV_O         <= 1'b0;
      RX_PIN_OE_N_O     <= 1'b1;
      TX_PIN_OE_N_O     <= 1'b1;
      TX_WEAK_PD_O      <= 1'b0;
      RX_PIN_O          <= 1'b0;
      TX_PIN_O          <= 1'b0;
    end else begin
      st_r              <= st_nxt;
      tmr_r             <= tmr_nxt;
      dom_r             <= dom_nxt;
      pwh_r             <= pwh_nxt;
      wlo_r             <= wlo_nxt;
      whi_r             <= whi_nxt;
      txh_r             <= txh_nxt;
      dom_prev_r        <= dom_s;
      en_prev_r         <= EN_I;
      bus_arm_r         <= bus_arm_nxt;
      wk_arm_r          <= wk_arm_nxt;
      pend_r            <= pend_nxt;
      src_loc_r         <= src_loc_nxt;
      ot_off_r          <= ot_off_nxt;
      txd_ok_r          <= txd_ok_nxt;
      REG_INHIBIT_OUT_O <= inh_nxt;
      TERM_EN_O         <= inh_nxt;
      RX_EN_O           <= rxen_nxt;
      BUS_DRV_O         <= drv_nxt;
      RX_PIN_OE_N_O     <= rxoe_nxt;
      TX_PIN_OE_N_O     <= txoe_nxt;
      TX_WEAK_PD_O      <= weak_nxt;
      RX_PIN_O          <= 1'b0;
      TX_PIN_O          <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // avalon slave
  // ---------------------------------------------------------------
  logic        req, wait_nxt;
  logic [31:0] rd_nxt, stat;

  assign req  = AVS_READ_I || AVS_WRITE_I;
  assign stat = {21'h0, bus_arm_r, wk_arm_r, txd_ok_r, ot_off_r,
                 src_loc_r, pend_r, st_r};

  // one wait cycle, write lands when waitrequest is low
  always_comb begin
    wait_nxt = !(req && AVS_WAITREQUEST_O);
    rd_nxt   = AVS_READDATA_O;
    ctrl_nxt = ctrl_r;
    if (AVS_READ_I && AVS_WAITREQUEST_O) begin
      unique case (AVS_ADDRESS_I)
        OFS_CTRL:   rd_nxt = {30'h0, ctrl_r};
        OFS_STATUS: rd_nxt = stat;
        default:    rd_nxt = 32'h0;
      endcase
    end
    if (AVS_WRITE_I && !AVS_WAITREQUEST_O &&
        (AVS_ADDRESS_I == OFS_CTRL) && AVS_BYTEENABLE_I[0])
      ctrl_nxt = AVS_WRITEDATA_I[1:0];
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O    <= 32'h0;
      ctrl_r            <= CTRL_RST;
    end else begin
      AVS_WAITREQUEST_O <= wait_nxt;
      AVS_READDATA_O    <= rd_nxt;
      ctrl_r            <= ctrl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_mon_rx_on: assert property (@(posedge CORE_CLK_I)
    disable iff (RESET_I) st_r == ST_MON |-> RX_EN_O)
    else $error("receiver off while monitoring");
  chk_remote_wake: assert property (@(posedge CORE_CLK_I)
    disable iff (RESET_I) rem_hit && !loc_hit |=> st_r == ST_FS &&
    REG_INHIBIT_OUT_O && TERM_EN_O && !src_loc_r)
    else $error("remote wake not taken");
  chk_pend_rx: assert property (@(posedge CORE_CLK_I)
    disable iff (RESET_I) st_r == ST_FS && pend_r |-> !RX_PIN_OE_N_O)
    else $error("wake request not on receive pin");
  chk_float_lock: assert property (@(posedge CORE_CLK_I)
    disable iff (RESET_I) st_r == ST_MON && tmr_r >= CW'(NMON) &&
    !dom_s && !loc_hit && !rem_hit |=> st_r == ST_SLEEP &&
    !bus_arm_r && !RX_EN_O)
    else $error("floating bus timeout wrong");
  chk_short_exit: assert property (@(posedge CORE_CLK_I)
    disable iff (RESET_I) st_r == ST_SHORT && $fell(dom_s)
    |=> st_r == ST_FS && pend_r)
    else $error("short release did not wake");
  chk_local_src: assert property (@(posedge CORE_CLK_I)
    disable iff (RESET_I) loc_hit |=> !TX_PIN_OE_N_O &&
    !RX_PIN_OE_N_O && !TX_WEAK_PD_O && !wk_arm_r)
    else $error("local wake source not shown");
  chk_en_clears: assert property (@(posedge CORE_CLK_I)
    disable iff (RESET_I) st_r == ST_FS && EN_I |=> st_r == ST_NORM &&
    !pend_r && TX_PIN_OE_N_O && !TX_WEAK_PD_O)
    else $error("wake flags not cleared");
  chk_ot_off: assert property (@(posedge CORE_CLK_I)
    disable iff (RESET_I) hot_s |=> !BUS_DRV_O && ot_off_r)
    else $error("driver on while hot");
  chk_txd_gate: assert property (@(posedge CORE_CLK_I)
    disable iff (RESET_I) $rose(st_r == ST_NORM) |-> !BUS_DRV_O [*8])
    else $error("driver on right after normal entry");
  chk_sleep_edge: assert property (@(posedge CORE_CLK_I)
    disable iff (RESET_I) st_r == ST_NORM && en_prev_r && !EN_I &&
    TX_PIN_I |=> st_r == ST_SLEEP && !REG_INHIBIT_OUT_O)
    else $error("sleep entry failed");
endmodule
`default_nettype wire

// ---- dv/lwm_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// host side: mode select, transmit pin with pull-up, receive pull-up
module lwm_host_model (
  input  wire logic en_cmd_i,
  input  wire logic tx_cmd_i,
  input  wire logic tx_drive_i,
  input  wire logic tx_oe_n_i,
  input  wire logic tx_pin_i,
  input  wire logic rx_oe_n_i,
  input  wire logic rx_pin_i,
  output logic      en_o,
  output logic      tx_o,
  output logic      rx_o
);
  // tx held high before mode select falls, and after normal entry
  assign en_o = en_cmd_i;
  // released pin: weak pull-down loses to pull-up, strong one wins
  assign tx_o = tx_drive_i ? tx_cmd_i :
                (tx_oe_n_i ? 1'b1 : tx_pin_i);
  // open-drain receive pin, pull-up when released
  assign rx_o = rx_oe_n_i ? 1'b1 : rx_pin_i;
endmodule
`default_nettype wire

// ---- dv/lin_wake_mode_controller_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module lin_wake_mode_controller_test;
  import lwm_pkg::*;
  localparam int NR = 8, NT = 10, NB = 20, NW = 20, NM = 40, NP = 8;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic        clk = 0, rst = 1, en_c = 0, tx_c = 1, tx_d = 0;
  logic        pwl = 0, pwh = 1, dom = 0, hot = 0, cool = 0, wake = 1;
  logic        rd = 0, wr = 0, pin_req = 0;
  logic [3:0]  adr = 4'h0, be = 4'hf;
  logic [31:0] wd = 32'h0, seed = 32'ha45e78db, rdat;
  logic        en_w, tx_w, rx_w, txoen, wpd, rxoen, regulator_inhibit_out, term, rxen;
  logic        drv, wreq, txp, rxp;
  int          failures = 0, checks_done = 0;
  logic [63:0] rd_q[$];
  logic [7:0]  pin_q[$];

  lwm_ctrl #(.NREARM(NR), .NTXD(NT), .NBUS(NB), .NWAKE(NW), .NMON(NM),
    .NPWH(NP)) i_lwm_ctrl (
    .CORE_CLK_I(clk), .RESET_I(rst), .EN_I(en_w), .TX_PIN_I(tx_w),
    .TX_PIN_O(txp), .TX_PIN_OE_N_O(txoen), .TX_WEAK_PD_O(wpd),
    .RX_PIN_O(rxp), .RX_PIN_OE_N_O(rxoen), .BUS_PWL_I(pwl),
    .BUS_PWH_I(pwh), .BUS_DOM_I(dom), .OT_HOT_I(hot), .OT_COOL_I(cool),
    .WAKE_I(wake), .REG_INHIBIT_OUT_O(regulator_inhibit_out), .TERM_EN_O(term),
    .RX_EN_O(rxen), .BUS_DRV_O(drv), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(be),
    .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wreq));

  lwm_host_model i_lwm_host_model (.en_cmd_i(en_c), .tx_cmd_i(tx_c),
    .tx_drive_i(tx_d), .tx_oe_n_i(txoen), .tx_pin_i(txp),
    .rx_oe_n_i(rxoen), .rx_pin_i(rxp),
    .en_o(en_w), .tx_o(tx_w), .rx_o(rx_w));

  // free-running core clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task final_report;
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [63:0] e);
    if (!w) rd_q.push_back(e);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // note expected pins {inh,term,rxen,drv,txoen,wpd,rx,tx}, then sample
  task automatic pins(input int n, input logic [7:0] e);
    repeat (n) @(posedge clk);
    pin_q.push_back(e);
    pin_req <= 1'b1;
    @(posedge clk);
    pin_req <= 1'b0;
  endtask

  // bus low with dominant level for n cycles, then rising edge
  task automatic pulse(input int n);
    pwl <= 1;
    pwh <= 0;
    dom <= 1;
    repeat (n) @(posedge clk);
    dom <= 0;
    pwl <= 0;
    pwh <= 1;
  endtask

  // fail-safe to normal, then falling mode select with tx high
  task automatic go_sleep;
    tx_d <= 1;
    tx_c <= 1;
    en_c <= 1;
    repeat (4) @(posedge clk);
    en_c <= 0;
    repeat (4) @(posedge clk);
    tx_d <= 0;
  endtask

  // result watcher: read data and pin snapshots against oldest note
  always @(posedge clk) begin
    logic [63:0] e;
    if (rd && wreq === 1'b0) begin
      e = rd_q.pop_front();
      check(rdat & e[63:32], e[31:0]);
    end
    if (pin_req)
      check({regulator_inhibit_out, term, rxen, drv, txoen, wpd, rx_w, tx_w}, pin_q.pop_front());
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    repeat (10) @(posedge clk);
    rst <= 0;
    pins(3, 8'heb);
    bus(0, OFS_CTRL, 0, {32'h3, 32'h3});
    bus(0, OFS_STATUS, 0, {32'h1f, 32'h08});
    bus(0, 4'h8, 0, {32'hffffffff, 32'h0});
    r = rnd();
    bus(1, OFS_CTRL, r, 0);
    bus(0, OFS_CTRL, 0, {32'h3, r & 32'h3});
    bus(1, OFS_CTRL, 32'h3, 0);
    // write without byte lane 0 must leave control untouched
    be <= 4'he;
    bus(1, OFS_CTRL, 32'h0, 0);
    be <= 4'hf;
    bus(0, OFS_CTRL, 0, {32'h3, 32'h3});
    tx_d <= 1;
    tx_c <= 0;
    en_c <= 1;
    pins(4, 8'hea);
    tx_c <= 1;
    repeat (NT + 4) @(posedge clk);
    tx_c <= 0;
    pins(3, 8'hfa);
    repeat (6) begin
      r = rnd();
      tx_c <= r[0];
      dom <= r[1];
      pwl <= r[1];
      pwh <= ~r[1];
      pins(5, {3'b111, ~r[0], 2'b10, ~r[1], r[0]});
    end
    dom <= 0;
    pwl <= 0;
    pwh <= 1;
    tx_c <= 0;
    hot <= 1;
    pins(5, 8'hea);
    hot <= 0;
    cool <= 1;
    pins(5, 8'hfa);
    cool <= 0;
    tx_c <= 1;
    en_c <= 0;
    pins(4, 8'h0b);
    bus(0, OFS_STATUS, 0, {32'h1f, 32'h01});
    tx_d <= 0;
    // remote wake disabled: a valid pulse must be ignored
    bus(1, OFS_CTRL, 32'h0, 0);
    pulse(NB + 6);
    pins(6, 8'h0b);
    bus(1, OFS_CTRL, 32'h3, 0);
    pulse(NB / 2);
    pins(6, 8'h0b);
    pulse(NB + 6);
    pins(6, 8'hed);
    tx_d <= 1;
    en_c <= 1;
    pins(4, 8'heb);
    en_c <= 0;
    pins(4, 8'h0b);
    tx_d <= 0;
    wake <= 0;
    pins(NW + 6, 8'he0);
    go_sleep;
    pins(3 * NW, 8'h0b);
    wake <= 1;
    repeat (NR / 2) @(posedge clk);
    wake <= 0;
    pins(NW + 6, 8'h0b);
    wake <= 1;
    repeat (NR + 4) @(posedge clk);
    wake <= 0;
    pins(NW + 6, 8'he0);
    wake <= 1;
    go_sleep;
    pwl <= 1;
    pwh <= 0;
    pins(5, 8'h2b);
    pins(NM + 6, 8'h0b);
    pwl <= 0;
    pwh <= 1;
    repeat (NP / 2) @(posedge clk);
    pulse(NB + 6);
    pins(6, 8'h0b);
    repeat (NP + 4) @(posedge clk);
    pulse(NB + 6);
    pins(6, 8'hed);
    pwl <= 1;
    pwh <= 0;
    dom <= 1;
    go_sleep;
    pins(NM + 10, 8'h0b);
    dom <= 0;
    pwl <= 0;
    pwh <= 1;
    pins(6, 8'hed);
    final_report;
  end
endmodule
`default_nettype wire
